// ---- verilog/ipm_pkg.sv ----
/*
 * constants shared by the interrupt pending-module identification block:
 * register indexes, id bit positions, reset values and bus states.
 * assumes a 32-bit avalon-mm slave port with byte addresses.
 */
`default_nettype none

package ipm_pkg;

   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int SRC_W = 8;
   localparam int GROUPS = 3;
   localparam int ADDR_W = 6;
   localparam int DATA_W = 32;
   localparam int REG_W = 8;
   localparam int BE_W = 4;

   // ----------------------------------------------------------------
   // register indexes, byte address is four times the index
   // ----------------------------------------------------------------
   localparam logic [3:0] IDX_PENDING_ID = 4'hB;
   localparam logic [3:0] IDX_EVT_STATUS = 4'hC;
   localparam logic [3:0] IDX_EVT_MASK = 4'hD;

   // ----------------------------------------------------------------
   // id fields and reset values
   // ----------------------------------------------------------------
   localparam int ID_BIT_M0 = 0;
   localparam int ID_BIT_M1 = 1;
   localparam int ID_BIT_SYS = 7;
   localparam int ID_RSV_LO = 2;
   localparam int ID_RSV_HI = 6;
   localparam logic [7:0] ID_RESET = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [7:0] EVENT_BITS = 8'h83;

   typedef enum logic [0:0] {
      BUS_IDLE,
      BUS_ANSWER
   } ipm_bus_e;

endpackage : ipm_pkg

`default_nettype wire

// ---- verilog/ipm_pending_or.sv ----
/*
 * one module group: pending when any source has flag and enable set.
 * assumes flags and enables come from logic on the same core clock.
 */
`timescale 1ns/1ps
`default_nettype none

module ipm_pending_or (
   input wire logic [ipm_pkg::SRC_W-1:0] i_flags,
   input wire logic [ipm_pkg::SRC_W-1:0] i_enables,
   output logic o_pending
);

   // ----------------------------------------------------------------
   // reduction
   // ----------------------------------------------------------------
   always_comb begin
      o_pending = |(i_flags & i_enables);
   end

endmodule : ipm_pending_or

`default_nettype wire

// ---- verilog/ipm_sticky_status.sv ----
/*
 * sticky event status, cleared by writing one; a set wins over a clear.
 * assumes set and clear pulses arrive on i_clock.
 */
`timescale 1ns/1ps
`default_nettype none

module ipm_sticky_status (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic [ipm_pkg::REG_W-1:0] i_set,
   input wire logic [ipm_pkg::REG_W-1:0] i_clear,
   output logic [ipm_pkg::REG_W-1:0] o_status
);

   logic [ipm_pkg::REG_W-1:0] status_r;
   logic [ipm_pkg::REG_W-1:0] status_nxt;

   // ----------------------------------------------------------------
   // status update
   // ----------------------------------------------------------------
   always_comb begin
      status_nxt = ((status_r & ~i_clear) | i_set) & ipm_pkg::EVENT_BITS;
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         status_r <= ipm_pkg::STATUS_RESET;
      end else begin
         status_r <= status_nxt;
      end
   end

   assign o_status = status_r;

   a_set_beats_clear: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (|(i_set & i_clear)) |=> (|(status_r & $past(i_set))))
      else $error("status set lost to a clear in the same cycle");

endmodule : ipm_sticky_status

`default_nettype wire

// ---- verilog/ipm_top.sv ----
/*
 * interrupt pending-module identification register with avalon-mm slave,
 * event status, mask and one level interrupt.
 * assumes flag and enable vectors come from the core clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

module ipm_top (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic [ipm_pkg::SRC_W-1:0] i_m0_flags,
   input wire logic [ipm_pkg::SRC_W-1:0] i_m0_enables,
   input wire logic [ipm_pkg::SRC_W-1:0] i_m1_flags,
   input wire logic [ipm_pkg::SRC_W-1:0] i_m1_enables,
   input wire logic [ipm_pkg::SRC_W-1:0] i_sys_flags,
   input wire logic [ipm_pkg::SRC_W-1:0] i_sys_enables,
   input wire logic [ipm_pkg::ADDR_W-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [ipm_pkg::DATA_W-1:0] i_avs_writedata,
   input wire logic [ipm_pkg::BE_W-1:0] i_avs_byteenable,
   output logic [ipm_pkg::DATA_W-1:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   output logic [ipm_pkg::REG_W-1:0] o_pending_id,
   output logic o_irq
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [ipm_pkg::GROUPS-1:0][ipm_pkg::SRC_W-1:0] flags_all;
   logic [ipm_pkg::GROUPS-1:0][ipm_pkg::SRC_W-1:0] enables_all;
   logic [ipm_pkg::GROUPS-1:0] group_pending;
   logic [ipm_pkg::REG_W-1:0] pending_id;
   logic run_r;
   logic run_nxt;
   logic [ipm_pkg::REG_W-1:0] prev_id_r;
   logic [ipm_pkg::REG_W-1:0] prev_id_nxt;
   logic [ipm_pkg::REG_W-1:0] event_set;
   logic [ipm_pkg::REG_W-1:0] event_clear;
   logic [ipm_pkg::REG_W-1:0] event_status;
   logic [ipm_pkg::REG_W-1:0] mask_r;
   logic [ipm_pkg::REG_W-1:0] mask_nxt;
   ipm_pkg::ipm_bus_e state_r;
   ipm_pkg::ipm_bus_e state_nxt;
   logic [ipm_pkg::DATA_W-1:0] readdata_r;
   logic [ipm_pkg::DATA_W-1:0] readdata_nxt;
   logic [3:0] reg_index;
   logic request;
   logic accept_write;
   logic accept_read;
   logic low_lane;

   // ----------------------------------------------------------------
   // address decode helper
   // ----------------------------------------------------------------
   function automatic logic reg_hit(
      input logic [3:0] index,
      input logic [3:0] target
   );
      reg_hit = (index == target);
   endfunction : reg_hit

   // ----------------------------------------------------------------
   // per-module pending reduction
   // ----------------------------------------------------------------
   assign flags_all = {i_sys_flags, i_m1_flags, i_m0_flags};
   assign enables_all = {i_sys_enables, i_m1_enables, i_m0_enables};

   generate
      for (genvar g = 0; g < ipm_pkg::GROUPS; g++) begin : g_group
         ipm_pending_or u_or (
            .i_flags(flags_all[g]),
            .i_enables(enables_all[g]),
            .o_pending(group_pending[g])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // identification value
   // ----------------------------------------------------------------
   // run_r holds the value at zero through reset and its release edge
   always_comb begin
      run_nxt = 1'b1;
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         run_r <= 1'b0;
      end else begin
         run_r <= run_nxt;
      end
   end

   // no storage: each bit follows its group in the same cycle
   always_comb begin
      pending_id = ipm_pkg::ID_RESET;
      if (run_r) begin
         pending_id[ipm_pkg::ID_BIT_M0] = group_pending[0];
         pending_id[ipm_pkg::ID_BIT_M1] = group_pending[1];
         pending_id[ipm_pkg::ID_BIT_SYS] = group_pending[2];
      end
   end

   assign o_pending_id = pending_id;

   // ----------------------------------------------------------------
   // rising id bits become events
   // ----------------------------------------------------------------
   always_comb begin
      prev_id_nxt = pending_id;
      event_set = pending_id & ~prev_id_r & ipm_pkg::EVENT_BITS;
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         prev_id_r <= ipm_pkg::ID_RESET;
      end else begin
         prev_id_r <= prev_id_nxt;
      end
   end

   // ----------------------------------------------------------------
   // avalon-mm slave, one wait state on every access
   // ----------------------------------------------------------------
   assign reg_index = i_avs_address[5:2];
   assign request = i_avs_read | i_avs_write;
   assign low_lane = i_avs_byteenable[0];
   assign accept_write = i_avs_write && (state_r == ipm_pkg::BUS_ANSWER);
   assign accept_read = i_avs_read && (state_r == ipm_pkg::BUS_ANSWER);
   assign o_avs_waitrequest = request && (state_r == ipm_pkg::BUS_IDLE);

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ipm_pkg::BUS_IDLE: begin
            if (request) begin
               state_nxt = ipm_pkg::BUS_ANSWER;
            end
         end
         ipm_pkg::BUS_ANSWER: begin
            state_nxt = ipm_pkg::BUS_IDLE;
         end
         default: begin
            state_nxt = ipm_pkg::BUS_IDLE;
         end
      endcase
   end

   // read data is caught at the wait edge and stands at the answer edge
   always_comb begin
      readdata_nxt = readdata_r;
      if (i_avs_read && (state_r == ipm_pkg::BUS_IDLE)) begin
         if (reg_hit(reg_index, ipm_pkg::IDX_PENDING_ID)) begin
            readdata_nxt = {24'h000000, pending_id};
         end else if (reg_hit(reg_index, ipm_pkg::IDX_EVT_STATUS)) begin
            readdata_nxt = {24'h000000, event_status};
         end else if (reg_hit(reg_index, ipm_pkg::IDX_EVT_MASK)) begin
            readdata_nxt = {24'h000000, mask_r};
         end else begin
            readdata_nxt = 32'h00000000;
         end
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_r <= ipm_pkg::BUS_IDLE;
         readdata_r <= 32'h00000000;
      end else begin
         state_r <= state_nxt;
         readdata_r <= readdata_nxt;
      end
   end

   assign o_avs_readdata = readdata_r;

   // ----------------------------------------------------------------
   // mask and status writes; the id register ignores writes
   // ----------------------------------------------------------------
   always_comb begin
      mask_nxt = mask_r;
      event_clear = 8'h00;
      if (accept_write && low_lane) begin
         if (reg_hit(reg_index, ipm_pkg::IDX_EVT_MASK)) begin
            mask_nxt = i_avs_writedata[7:0] & ipm_pkg::EVENT_BITS;
         end else if (reg_hit(reg_index, ipm_pkg::IDX_EVT_STATUS)) begin
            event_clear = i_avs_writedata[7:0];
         end
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mask_r <= ipm_pkg::MASK_RESET;
      end else begin
         mask_r <= mask_nxt;
      end
   end

   ipm_sticky_status u_status (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_set(event_set),
      .i_clear(event_clear),
      .o_status(event_status)
   );

   // ----------------------------------------------------------------
   // interrupt output
   // ----------------------------------------------------------------
   assign o_irq = |(event_status & mask_r);

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_reset_id_zero: assert property (
      @(posedge i_clock) disable iff (!i_rst_n)
      !run_r |-> (o_pending_id == ipm_pkg::ID_RESET))
      else $error("id not zero right after reset");

   a_write_id_noop: assert property (
      @(posedge i_clock) disable iff (!i_rst_n)
      (accept_write && reg_hit(reg_index, ipm_pkg::IDX_PENDING_ID))
      |=> ($stable(mask_r) && (event_status == ($past(event_status) | $past(event_set)))))
      else $error("write to id register changed state");

   a_module0_bit: assert property (
      @(posedge i_clock) disable iff (!i_rst_n)
      run_r |-> (o_pending_id[ipm_pkg::ID_BIT_M0] == |(i_m0_flags & i_m0_enables)))
      else $error("module 0 id bit wrong");

   a_module0_clear: assert property (
      @(posedge i_clock) disable iff (!i_rst_n)
      ((i_m0_flags & i_m0_enables) == 8'h00) |-> !o_pending_id[ipm_pkg::ID_BIT_M0])
      else $error("module 0 id bit not cleared");

   a_module1_bit: assert property (
      @(posedge i_clock) disable iff (!i_rst_n)
      run_r |-> (o_pending_id[ipm_pkg::ID_BIT_M1] == |(i_m1_flags & i_m1_enables)))
      else $error("module 1 id bit wrong");

   a_module1_clear: assert property (
      @(posedge i_clock) disable iff (!i_rst_n)
      $fell(|(i_m1_flags & i_m1_enables)) |-> !o_pending_id[ipm_pkg::ID_BIT_M1])
      else $error("module 1 id bit not cleared");

   a_system_bit: assert property (
      @(posedge i_clock) disable iff (!i_rst_n)
      run_r |-> (o_pending_id[ipm_pkg::ID_BIT_SYS] == |(i_sys_flags & i_sys_enables)))
      else $error("system id bit wrong");

   a_system_clear: assert property (
      @(posedge i_clock) disable iff (!i_rst_n)
      ((i_sys_flags & i_sys_enables) == 8'h00) |-> !o_pending_id[ipm_pkg::ID_BIT_SYS])
      else $error("system id bit not cleared");

   a_reserved_zero: assert property (
      @(posedge i_clock) disable iff (!i_rst_n)
      o_pending_id[ipm_pkg::ID_RSV_HI:ipm_pkg::ID_RSV_LO] == 5'h00)
      else $error("reserved id bits not zero");

   a_read_live_id: assert property (
      @(posedge i_clock) disable iff (!i_rst_n)
      (accept_read && reg_hit(reg_index, ipm_pkg::IDX_PENDING_ID))
      |-> (o_avs_readdata == {24'h000000, $past(pending_id)}))
      else $error("id read does not match pending state");

   a_bus_answer: assert property (
      @(posedge i_clock) disable iff (!i_rst_n)
      $rose(request) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
      else $error("bus answer not after one wait state");

   a_irq_level: assert property (
      @(posedge i_clock) disable iff (!i_rst_n)
      (|event_set && |(mask_r & event_set)) |=> o_irq)
      else $error("unmasked event did not raise interrupt");

   c_id_read: cover property (@(posedge i_clock) disable iff (!i_rst_n)
      accept_read && reg_hit(reg_index, ipm_pkg::IDX_PENDING_ID) && |o_avs_readdata);

   c_all_pending: cover property (@(posedge i_clock) disable iff (!i_rst_n)
      pending_id == ipm_pkg::EVENT_BITS);

   c_irq_cleared: cover property (@(posedge i_clock) disable iff (!i_rst_n)
      $fell(o_irq));

endmodule : ipm_top

`default_nettype wire

// ---- tb/tb_interrupt_source_identification.sv ----
/*
 * self-checking bench for the pending-module identification block (ipm_top).
 * assumes a 10 MHz core clock, an avalon-mm master held until waitrequest
 * drops, and flag/enable vectors driven from the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; $display("mismatch %s expected %0h seen %0h", n, e, g); end end

module tb_interrupt_source_identification;
   logic i_clock = 1'h0;
   logic i_rst_n = 1'h0;
   logic [ipm_pkg::SRC_W-1:0] fl [3] = '{default: 8'h00};
   logic [ipm_pkg::SRC_W-1:0] en [3] = '{default: 8'h00};
   logic [ipm_pkg::ADDR_W-1:0] adr = 6'h00;
   logic rd = 1'h0;
   logic wr = 1'h0;
   logic [ipm_pkg::DATA_W-1:0] wdat = 32'h0000_0000;
   logic [ipm_pkg::BE_W-1:0] be = 4'h0;
   logic [ipm_pkg::DATA_W-1:0] rdat;
   logic wreq;
   logic [ipm_pkg::REG_W-1:0] pid;
   logic irq;
   logic [31:0] mexp;
   logic [31:0] expq [$];
   int fails = 0;
   int cmp_count = 0;

   always #50 i_clock = ~i_clock;

   ipm_top ipm_top_inst (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_m0_flags(fl[0]),
      .i_m0_enables(en[0]),
      .i_m1_flags(fl[1]),
      .i_m1_enables(en[1]),
      .i_sys_flags(fl[2]),
      .i_sys_enables(en[2]),
      .i_avs_address(adr),
      .i_avs_read(rd),
      .i_avs_write(wr),
      .i_avs_writedata(wdat),
      .i_avs_byteenable(be),
      .o_avs_readdata(rdat),
      .o_avs_waitrequest(wreq),
      .o_pending_id(pid),
      .o_irq(irq)
   );

   // ----------------------------------------------------------------
   // expectations and bus master
   // ----------------------------------------------------------------
   function automatic logic [7:0] exp_id();
      return {|(fl[2] & en[2]), 5'h00, |(fl[1] & en[1]), |(fl[0] & en[0])};
   endfunction : exp_id

   task automatic bus(input logic [5:0] a, input logic w, input logic [31:0] d,
                      input logic [3:0] b);
      int n;
      adr <= a;
      rd <= ~w;
      wr <= w;
      wdat <= d;
      be <= b;
      n = 0;
      do begin
         @(posedge i_clock);
         n++;
      end while (wreq !== 1'h0 && n < 50);
      if (n >= 50) begin
         fails++;
         $display("mismatch waitrequest expected 0 seen %0h", wreq);
      end
      rd <= 1'h0;
      wr <= 1'h0;
      @(posedge i_clock);
   endtask : bus

   task automatic rdc(input logic [5:0] a, input logic [31:0] e);
      expq.push_back(e);
      bus(a, 1'h0, 32'h0000_0000, 4'hF);
   endtask : rdc

   task automatic wrc(input logic [5:0] a, input logic [31:0] d, input logic [3:0] b);
      bus(a, 1'h1, d, b);
   endtask : wrc

   // live id checked in the same cycle that the sources change
   task automatic settle();
      @(negedge i_clock);
      `CHK("pending_id", exp_id(), pid)
      @(posedge i_clock);
   endtask : settle

   task automatic chk_irq(input logic e);
      @(negedge i_clock);
      `CHK("irq", e, irq)
      @(posedge i_clock);
   endtask : chk_irq

   // ----------------------------------------------------------------
   // read-data monitor
   // ----------------------------------------------------------------
   always @(posedge i_clock) begin
      if (i_rst_n && rd && wreq === 1'h0) begin
         mexp = (expq.size() > 0) ? expq.pop_front() : 32'hDEAD_BEEF;
         `CHK("readdata", mexp, rdat)
      end
   end

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      repeat (20000) @(posedge i_clock);
      fails++;
      $display("mismatch watchdog expected done seen hang");
      report_and_stop();
   end

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(32'h5649B8E0));
      repeat (16) @(posedge i_clock);
      i_rst_n <= 1'h1;
      @(negedge i_clock);
      `CHK("pending_id", 8'h00, pid)
      @(posedge i_clock);
      rdc(6'h2C, 32'h0000_0000);
      rdc(6'h34, 32'h0000_0000);
      $display("test reset values done");

      for (int i = 0; i < 40; i++) begin
         for (int g = 0; g < 3; g++) begin
            fl[g] <= 8'($urandom & $urandom);
            en[g] <= 8'($urandom & $urandom);
         end
         settle();
         rdc(6'h2C, {24'h00_0000, exp_id()});
      end
      $display("test random sources done");

      for (int g = 0; g < 3; g++) begin
         for (int k = 0; k < 3; k++) begin
            fl[k] <= (k == g) ? 8'(8'h01 << (g * 3)) : 8'h00;
            en[k] <= (k == g) ? 8'((8'h01 << (g * 3)) | 8'h10) : 8'h00;
         end
         settle();
         en[g] <= 8'h10;
         settle();
         en[g] <= 8'hFF;
         settle();
         fl[g] <= 8'h00;
         settle();
      end
      fl <= '{default: 8'hFF};
      en <= '{default: 8'hFF};
      settle();
      wrc(6'h2C, 32'h0000_0000, 4'hF);
      rdc(6'h2C, 32'h0000_0083);
      wrc(6'h2C, 32'hFFFF_FFFF, 4'hF);
      rdc(6'h2C, 32'h0000_0083);
      $display("test set and clear per module done");

      fl <= '{default: 8'h00};
      settle();
      wrc(6'h34, 32'h0000_0001, 4'hF);
      wrc(6'h34, 32'h0000_0082, 4'h0);
      rdc(6'h34, 32'h0000_0001);
      wrc(6'h30, 32'h0000_00FF, 4'hF);
      rdc(6'h30, 32'h0000_0000);
      chk_irq(1'h0);
      fl[0] <= 8'h04;
      settle();
      chk_irq(1'h1);
      fl[1] <= 8'h80;
      settle();
      rdc(6'h30, 32'h0000_0003);
      wrc(6'h30, 32'h0000_0001, 4'hF);
      chk_irq(1'h0);
      rdc(6'h30, 32'h0000_0002);
      fl[0] <= 8'h00;
      settle();
      // id bit 0 rises in the cycle the clearing write is accepted: set wins
      fork
         wrc(6'h30, 32'h0000_0001, 4'hF);
         begin
            @(posedge i_clock);
            fl[0] <= 8'h04;
         end
      join
      rdc(6'h30, 32'h0000_0003);
      chk_irq(1'h1);
      rdc(6'h3C, 32'h0000_0000);
      $display("test interrupt status and mask done");

      fl <= '{default: 8'hFF};
      settle();
      i_rst_n <= 1'h0;
      @(negedge i_clock);
      `CHK("pending_id", 8'h00, pid)
      @(posedge i_clock);
      i_rst_n <= 1'h1;
      @(negedge i_clock);
      `CHK("pending_id", 8'h00, pid)
      @(posedge i_clock);
      settle();
      rdc(6'h34, 32'h0000_0000);
      rdc(6'h2C, 32'h0000_0083);
      $display("test reset in mid run done");
      report_and_stop();
   end

endmodule : tb_interrupt_source_identification

`default_nettype wire
